// *** sgip_pkg.sv ***
package sgip_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] master_config_3_off     = 8'h00;
    localparam logic [7:0] master_config_6_off     = 8'h04;
    localparam logic [7:0] general_pin_control_off = 8'h08;
    localparam logic [7:0] general_pin_state_off   = 8'h0c;
    localparam logic [7:0] irq_pin_config_off      = 8'h10;
    localparam logic [7:0] irq_status_off          = 8'h14;
    localparam logic [7:0] irq_mask_off            = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int rate_family_select_bit      = 0;
    localparam int digital_out1_rate_family_bit = 0;
    localparam int digital_out2_rate_family_bit = 1;
    localparam int pin4_direction_bit           = 0;
    localparam int pin4_output_value_bit        = 1;
    localparam int multi_use_pin4_bit           = 0;
    localparam int reference_missing_mode_bit   = 0;
    localparam int irq_active_high_bit          = 1;
    localparam int irq_open_drain_bit           = 2;
    localparam int irq_gp_output_bit            = 3;
    localparam int irq_gp_value_bit             = 4;
    localparam int ev_pin4_change_bit           = 0;
    localparam int ev_ref_lost_bit              = 1;
    localparam int ev_ref_back_bit              = 2;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          event_count     = 3;
    localparam logic [4:0]  irq_config_rst  = 5'h00;
    localparam logic [2:0]  mask_rst        = 3'h0;
    localparam logic        rate_sdh        = 1'b0;
    localparam logic        rate_sonet      = 1'b1;
    localparam logic [31:0] word_zero       = 32'h0000_0000;

    typedef enum logic {sgip_strap_wait, sgip_running} sgip_phase_e;

endpackage

// *** sgip_sync_if.sv ***
`timescale 1ns/1ns
interface sgip_sync_if;
    logic pin_async;
    logic pin_level;
    modport src (output pin_async, input pin_level);
    modport snk (input pin_async, output pin_level);
endinterface

// *** sgip_sync.sv ***
`timescale 1ns/1ns
module sgip_sync
(
    // Clock
    input  wire logic clock,
    // Pin level
    sgip_sync_if.snk  sif
);

    typedef struct packed
    {
        logic first;
        logic second;
    } sgip_sync_s;

    sgip_sync_s state;
    sgip_sync_s next_state;

    // The first stage feeds only the second stage.
    always_comb
    begin
        next_state.first  = sif.pin_async;
        next_state.second = state.first;
    end

    // No reset here: the strap level must already be through both stages when reset is released.
    always_ff @(posedge clock)
    begin
        state <= next_state;
    end

    assign sif.pin_level = state.second;

endmodule

// *** sgip_irq_drive.sv ***
`timescale 1ns/1ns
module sgip_irq_drive
(
    // Selection
    input  wire logic       los_mode,
    input  wire logic       gp_output,
    input  wire logic       gp_value,
    input  wire logic       active_high,
    input  wire logic       open_drain,
    // Sources
    input  wire logic       irq_req,
    input  wire logic       ref_missing,
    // Pin drive
    output logic            next_out,
    output logic            next_oe
);

    logic asserted_level;

    always_comb
    begin
        asserted_level = active_high;
        next_out = 1'b0;
        next_oe  = 1'b1;
        if (los_mode)
        begin
            // Live monitor level, no latching. [RULE10]
            next_out = ref_missing;
        end
        else if (gp_output)
        begin
            next_out = gp_value; // [RULE9]
        end
        else
        begin
            next_out = irq_req ? asserted_level : ~asserted_level; // [RULE7]
            if (open_drain && !irq_req)
            begin
                next_oe = 1'b0; // [RULE8] [RULE11]
            end
        end
    end

endmodule

// *** sgip_pin_logic.sv ***
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
// Functional notes
// [RULE1] On reset release, strap pin level loads rate family and both output families.
// [RULE2] Strap 0 means SDH rate family, 1 means SONET rate family.
// [RULE3] After reset the strap pin is a GPIO with a direction bit.
// [RULE4] As output, the GPIO drives the output-value bit.
// [RULE5] A status bit reports the current GPIO pin level.
// [RULE6] Interrupt pin mode bit: 0 request, 1 reference-missing; default request.
// [RULE7] Request polarity is software selectable, active high or low.
// [RULE8] Push-pull or open-drain drive; open-drain releases the inactive pin. Here open-drain acts in request mode only; other modes always drive.
// [RULE9] Interrupt pin may be a software-controlled general output.
// [RULE10] Reference-missing mode drives the live activity monitor level, unlatched.
// [RULE11] The interrupt pin driver can be placed in high impedance.
// [RULE12] GPIO input is synchronised; strap ignored once reset is released.
module sgip_pin_logic
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Strap and general-purpose pin
    input  wire logic        multi_use_pin4_in,
    output logic             multi_use_pin4_out,
    output logic             multi_use_pin4_oe,
    // Interrupt request pin
    output logic             irq_pin_out,
    output logic             irq_pin_oe,
    // Reference activity monitor and system interrupt
    input  wire logic        ref_missing,
    output logic             irq
);

    typedef struct packed
    {
        sgip_pkg::sgip_phase_e phase;
        logic                  rate_family_select;
        logic [1:0]            digital_out_family;
        logic                  pin4_direction;
        logic                  pin4_output_value;
        logic [4:0]            irq_pin_config;
        logic [2:0]            status;
        logic [2:0]            mask;
        logic                  pin_prev;
        logic                  ref_prev;
        logic                  dphase;
        logic                  dwrite;
        logic [7:0]            daddr;
        logic [31:0]           rdata;
        logic                  pin4_out;
        logic                  pin4_oe;
        logic                  irq_out;
        logic                  irq_oe;
        logic                  irq;
    } sgip_state_s;

    sgip_state_s state;
    sgip_state_s next_state;

    // ------------------------------------------------------------------
    // Pin synchroniser and interrupt pin drive
    // ------------------------------------------------------------------
    sgip_sync_if sif ();
    logic        pin_level;
    logic        ref_level;
    logic        drv_out;
    logic        drv_oe;

    assign sif.pin_async = multi_use_pin4_in;
    assign pin_level     = sif.pin_level;

    sgip_sync u_sync
    (
        .clock (clock),
        .sif   (sif)
    );

    // The monitor is on this clock, so it is used without synchronising.
    assign ref_level = ref_missing;

    sgip_irq_drive u_drive
    (
        .los_mode    (state.irq_pin_config[sgip_pkg::reference_missing_mode_bit]),
        .gp_output   (state.irq_pin_config[sgip_pkg::irq_gp_output_bit]),
        .gp_value    (state.irq_pin_config[sgip_pkg::irq_gp_value_bit]),
        .active_high (state.irq_pin_config[sgip_pkg::irq_active_high_bit]),
        .open_drain  (state.irq_pin_config[sgip_pkg::irq_open_drain_bit]),
        .irq_req     (next_state.irq),
        .ref_missing (ref_level),
        .next_out    (drv_out),
        .next_oe     (drv_oe)
    );

    function automatic logic [31:0] bit_word(input logic b);
        bit_word = {31'h0000_0000, b};
    endfunction

    logic [2:0]  events;
    logic [2:0]  rd_clear;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        events     = 3'h0;
        rd_clear   = 3'h0;

        unique case (state.phase)
            sgip_pkg::sgip_strap_wait:
            begin
                // First cycle after release: take the synchronised strap once. [RULE1] [RULE2]
                next_state.rate_family_select = pin_level;
                next_state.digital_out_family = {pin_level, pin_level};
                next_state.phase              = sgip_pkg::sgip_running;
            end
            sgip_pkg::sgip_running:
            begin
                // Strap level no longer reaches the defaults. [RULE12]
                next_state.phase = sgip_pkg::sgip_running;
            end
        endcase

        // Data phase of a write.
        if (state.dphase && state.dwrite)
        begin
            unique case (state.daddr)
                sgip_pkg::master_config_3_off:
                    next_state.rate_family_select = hwdata[sgip_pkg::rate_family_select_bit];
                sgip_pkg::master_config_6_off:
                    next_state.digital_out_family = hwdata[1:0];
                sgip_pkg::general_pin_control_off:
                begin
                    next_state.pin4_direction    = hwdata[sgip_pkg::pin4_direction_bit];
                    next_state.pin4_output_value = hwdata[sgip_pkg::pin4_output_value_bit];
                end
                sgip_pkg::irq_pin_config_off:
                    next_state.irq_pin_config = hwdata[4:0]; // [RULE6]
                sgip_pkg::irq_mask_off:
                    next_state.mask = hwdata[2:0];
                default:
                    next_state.mask = state.mask;
            endcase
        end

        // Address phase: zero wait state, always OKAY.
        next_state.dphase = hsel && hready && htrans[1];
        next_state.dwrite = hwrite;
        next_state.daddr  = haddr[7:0];
        next_state.rdata  = sgip_pkg::word_zero;
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            unique case (haddr[7:0])
                sgip_pkg::master_config_3_off:
                    next_state.rdata = bit_word(next_state.rate_family_select);
                sgip_pkg::master_config_6_off:
                    next_state.rdata = {30'h0000_0000, next_state.digital_out_family};
                sgip_pkg::general_pin_control_off:
                    next_state.rdata = {30'h0000_0000, next_state.pin4_output_value, next_state.pin4_direction};
                sgip_pkg::general_pin_state_off:
                    next_state.rdata = bit_word(pin_level); // [RULE5]
                sgip_pkg::irq_pin_config_off:
                    next_state.rdata = {27'h0000_000, next_state.irq_pin_config};
                sgip_pkg::irq_status_off:
                begin
                    next_state.rdata = {29'h0000_000, state.status};
                    rd_clear         = 3'h7;
                end
                sgip_pkg::irq_mask_off:
                    next_state.rdata = {29'h0000_000, next_state.mask};
                default:
                    next_state.rdata = sgip_pkg::word_zero;
            endcase
        end

        // Events: pin change, reference lost, reference back. Set wins over read clear.
        next_state.pin_prev = pin_level;
        next_state.ref_prev = ref_level;
        events[sgip_pkg::ev_pin4_change_bit] = (pin_level != state.pin_prev)
                                               && (state.phase == sgip_pkg::sgip_running);
        events[sgip_pkg::ev_ref_lost_bit]    = ref_level && !state.ref_prev;
        events[sgip_pkg::ev_ref_back_bit]    = !ref_level && state.ref_prev;
        next_state.status = (state.status & ~rd_clear) | events;
        next_state.irq    = |(next_state.status & next_state.mask);

        // General-purpose pin drive after reset. [RULE3] [RULE4]
        next_state.pin4_oe  = next_state.pin4_direction;
        next_state.pin4_out = next_state.pin4_output_value;

        next_state.irq_out = drv_out;
        next_state.irq_oe  = drv_oe;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state                    <= '0;
            state.phase              <= sgip_pkg::sgip_strap_wait;
            state.rate_family_select <= sgip_pkg::rate_sdh;
            state.irq_pin_config     <= sgip_pkg::irq_config_rst; // [RULE6]
            state.mask               <= sgip_pkg::mask_rst;
            state.irq_oe             <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign hrdata             = state.rdata;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign multi_use_pin4_out = state.pin4_out;
    assign multi_use_pin4_oe  = state.pin4_oe;
    assign irq_pin_out        = state.irq_out;
    assign irq_pin_oe         = state.irq_oe;
    assign irq                = state.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_strap_load;
        @(posedge clock) disable iff (srst)
        (state.phase == sgip_pkg::sgip_strap_wait) |=> (state.rate_family_select == $past(pin_level))
            && (state.digital_out_family == {2{$past(pin_level)}});
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("strap not loaded"); // [RULE1]

    property p_sonet;
        @(posedge clock) disable iff (srst)
        (state.phase == sgip_pkg::sgip_strap_wait && pin_level) |=> state.rate_family_select == sgip_pkg::rate_sonet;
    endproperty
    a_sonet: assert property (p_sonet) else $error("strap high not sonet"); // [RULE2]

    property p_gpio_dir;
        @(posedge clock) disable iff (srst)
        (state.dphase && state.dwrite && state.daddr == sgip_pkg::general_pin_control_off)
            |=> ##1 (multi_use_pin4_oe == $past(hwdata[sgip_pkg::pin4_direction_bit], 2));
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("direction wrong"); // [RULE3]

    property p_gpio_out;
        @(posedge clock) disable iff (srst)
        multi_use_pin4_oe |-> multi_use_pin4_out == state.pin4_output_value;
    endproperty
    a_gpio_out: assert property (p_gpio_out) else $error("pin value wrong"); // [RULE4]

    property p_state_read;
        @(posedge clock) disable iff (srst)
        (hsel && hready && htrans[1] && !hwrite && haddr[7:0] == sgip_pkg::general_pin_state_off)
            |=> hrdata[0] == $past(pin_level);
    endproperty
    a_state_read: assert property (p_state_read) else $error("pin state read wrong"); // [RULE5]

    property p_los;
        @(posedge clock) disable iff (srst)
        state.irq_pin_config[sgip_pkg::reference_missing_mode_bit] |=> irq_pin_out == $past(ref_missing);
    endproperty
    a_los: assert property (p_los) else $error("loss mode not live"); // [RULE10]

    property p_polarity;
        @(posedge clock) disable iff (srst)
        (state.irq_pin_config[0] == 1'b0 && state.irq_pin_config[3] == 1'b0)
            |=> irq_pin_out == (irq ~^ $past(state.irq_pin_config[sgip_pkg::irq_active_high_bit]));
    endproperty
    a_polarity: assert property (p_polarity) else $error("request polarity wrong"); // [RULE7]

    property p_open_drain;
        @(posedge clock) disable iff (srst)
        ($past(state.irq_pin_config) == 5'h04 && state.irq_pin_config == 5'h04 && !irq) |-> !irq_pin_oe;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain not released"); // [RULE8]

    property p_gp_irq;
        @(posedge clock) disable iff (srst)
        (state.irq_pin_config[1:0] == 2'b00 && state.irq_pin_config[3]) |=> irq_pin_out == $past(state.irq_pin_config[4]);
    endproperty
    a_gp_irq: assert property (p_gp_irq) else $error("gp output wrong"); // [RULE9]

    property p_strap_ignored;
        @(posedge clock) disable iff (srst)
        (state.phase == sgip_pkg::sgip_running && !(state.dphase && state.dwrite
            && state.daddr == sgip_pkg::master_config_3_off)) |=> $stable(state.rate_family_select);
    endproperty
    a_strap_ignored: assert property (p_strap_ignored) else $error("strap reached defaults after reset"); // [RULE12]

    property p_irq_default;
        @(posedge clock) disable iff (srst)
        $past(srst) |-> state.irq_pin_config == sgip_pkg::irq_config_rst;
    endproperty
    a_irq_default: assert property (p_irq_default) else $error("interrupt pin not in request mode after reset"); // [RULE6]

endmodule

// *** sgip_board_model.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Board logic around the two multi-function pins
// ------------------------------------------------------------------
module sgip_board_model
(
    // Device drive of the strap and general-purpose pin
    input  wire logic pin4_out,
    input  wire logic pin4_oe,
    // Board driver sharing that wire
    input  wire logic board_en,
    input  wire logic board_level,
    output logic      pin4_wire,
    // Device drive of the interrupt pin
    input  wire logic irq_out,
    input  wire logic irq_oe,
    output logic      irq_wire
);
    always_comb
    begin
        // Two drivers at once is a board fault, so it shows as unknown rather than a guess.
        if (pin4_oe && board_en)
        begin
            pin4_wire = 1'bx;
        end
        else if (pin4_oe)
        begin
            pin4_wire = pin4_out;
        end
        else if (board_en)
        begin
            pin4_wire = board_level;
        end
        else
        begin
            // The pin has a weak pull-down, so a released wire reads low.
            pin4_wire = 1'b0;
        end
    end

    // An open-drain request line needs a board pull-up to read high when released.
    assign irq_wire = irq_oe ? irq_out : 1'b1;
endmodule

// *** tb_strap_gpio_irq_pin_logic.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module tb_strap_gpio_irq_pin_logic;
    logic        clock;
    logic        srst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin4_out;
    logic        pin4_oe;
    logic        pin4_wire;
    logic        irq_pin_out;
    logic        irq_pin_oe;
    logic        irq_wire;
    logic        ref_missing;
    logic        irq;
    logic        board_en;
    logic        board_level;
    int          mismatches;
    int          n_checks;

    always #2 clock = ~clock;

    sgip_pin_logic sgip_pin_logic_inst
    (
        .clock              (clock),
        .srst               (srst),
        .hsel               (hsel),
        .haddr              (haddr),
        .htrans             (htrans),
        .hwrite             (hwrite),
        .hsize              (hsize),
        .hwdata             (hwdata),
        .hready             (hreadyout),
        .hrdata             (hrdata),
        .hreadyout          (hreadyout),
        .hresp              (hresp),
        .multi_use_pin4_in  (pin4_wire),
        .multi_use_pin4_out (pin4_out),
        .multi_use_pin4_oe  (pin4_oe),
        .irq_pin_out        (irq_pin_out),
        .irq_pin_oe         (irq_pin_oe),
        .ref_missing        (ref_missing),
        .irq                (irq)
    );

    sgip_board_model sgip_board_model_inst
    (
        .pin4_out    (pin4_out),
        .pin4_oe     (pin4_oe),
        .board_en    (board_en),
        .board_level (board_level),
        .pin4_wire   (pin4_wire),
        .irq_out     (irq_pin_out),
        .irq_oe      (irq_pin_oe),
        .irq_wire    (irq_wire)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Waits for hready at a rising edge; a wait that never ends counts as a mismatch.
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            mismatches++;
            $display("MISMATCH hready expected 1 seen %b", hreadyout);
            tally_and_finish();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        bus(1'b0, a, 32'h0000_0000, d);
        `CHK(nm, e, d)
    endtask

    task automatic pin_chk(input logic oe, input logic lvl);
        `CHK("irq_pin_oe", oe, irq_pin_oe)
        `CHK("irq_wire", lvl, irq_wire)
    endtask

    // The strap level is held well before and after the release, as the pin input is synchronised.
    task automatic do_reset(input logic strap);
        board_en    <= 1'b1;
        board_level <= strap;
        srst        <= 1'b1;
        ticks(2);
        srst        <= 1'b0;
        ticks(2);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [4:0] cfg;
        logic       act;
        clock = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0000_0000; ref_missing = 1'b0;
        mismatches = 0; n_checks = 0;
        do_reset(1'b1);
        ticks(2);
        rd_chk("rate family", sgip_pkg::master_config_3_off, 32'h0000_0001);
        rd_chk("output families", sgip_pkg::master_config_6_off, 32'h0000_0003);
        rd_chk("irq config", sgip_pkg::irq_pin_config_off, 32'h0000_0000);
        rd_chk("mask", sgip_pkg::irq_mask_off, 32'h0000_0000);
        pin_chk(1'b1, 1'b1);
        `CHK("pin4 oe", 1'b0, pin4_oe)
        board_level <= 1'b0;
        ticks(4);
        rd_chk("pin state low", sgip_pkg::general_pin_state_off, 32'h0000_0000);
        rd_chk("strap ignored", sgip_pkg::master_config_3_off, 32'h0000_0001);
        board_level <= 1'b1;
        ticks(4);
        rd_chk("pin state high", sgip_pkg::general_pin_state_off, 32'h0000_0001);
        wr(8'h40, 32'hffff_ffff);
        rd_chk("unmapped", 8'h40, 32'h0000_0000);
        wr(sgip_pkg::master_config_3_off, 32'h0000_0000);
        rd_chk("rate family write", sgip_pkg::master_config_3_off, 32'h0000_0000);
        rd_chk("status pin change", sgip_pkg::irq_status_off, 32'h0000_0001);
        rd_chk("status cleared", sgip_pkg::irq_status_off, 32'h0000_0000);
        wr(sgip_pkg::irq_mask_off, 32'h0000_0001);
        board_level <= 1'b0;
        ticks(5);
        `CHK("irq raised", 1'b1, irq)
        // Every polarity and drive combination, first with the request asserted, then released.
        for (int pass = 0; pass < 2; pass++)
        begin
            act = (pass == 0);
            if (pass == 1)
            begin
                rd_chk("status before release", sgip_pkg::irq_status_off, 32'h0000_0001);
                ticks(3);
                `CHK("irq cleared", 1'b0, irq)
            end
            for (int m = 0; m < 4; m++)
            begin
                cfg = {2'b00, m[1:0], 1'b0};
                wr(sgip_pkg::irq_pin_config_off, {27'h0000000, cfg});
                ticks(2);
                if (act)
                    pin_chk(1'b1, cfg[1]);
                else if (cfg[2])
                    pin_chk(1'b0, 1'b1);
                else
                    pin_chk(1'b1, ~cfg[1]);
            end
        end
        wr(sgip_pkg::irq_pin_config_off, 32'h0000_0008);
        ticks(2);
        pin_chk(1'b1, 1'b0);
        wr(sgip_pkg::irq_pin_config_off, 32'h0000_0018);
        ticks(2);
        pin_chk(1'b1, 1'b1);
        board_en <= 1'b0;
        wr(sgip_pkg::general_pin_control_off, 32'h0000_0003);
        ticks(2);
        `CHK("pin4 oe out", 1'b1, pin4_oe)
        `CHK("pin4 drive high", 1'b1, pin4_wire)
        ticks(3);
        rd_chk("pin state driven high", sgip_pkg::general_pin_state_off, 32'h0000_0001);
        wr(sgip_pkg::general_pin_control_off, 32'h0000_0001);
        ticks(2);
        `CHK("pin4 drive low", 1'b0, pin4_wire)
        ticks(3);
        rd_chk("pin state driven low", sgip_pkg::general_pin_state_off, 32'h0000_0000);
        wr(sgip_pkg::general_pin_control_off, 32'h0000_0000);
        ticks(2);
        `CHK("pin4 released", 1'b0, pin4_oe)
        board_en <= 1'b1;
        ticks(5);
        wr(sgip_pkg::irq_mask_off, 32'h0000_0006);
        rd_chk("status flush", sgip_pkg::irq_status_off, 32'h0000_0001);
        wr(sgip_pkg::irq_pin_config_off, 32'h0000_0001);
        ticks(2);
        pin_chk(1'b1, 1'b0);
        ref_missing <= 1'b1;
        ticks(3);
        pin_chk(1'b1, 1'b1);
        ref_missing <= 1'b0;
        ticks(3);
        pin_chk(1'b1, 1'b0);
        `CHK("irq ref events", 1'b1, irq)
        rd_chk("ref events", sgip_pkg::irq_status_off, 32'h0000_0006);
        do_reset(1'b0);
        rd_chk("rate family sdh", sgip_pkg::master_config_3_off, 32'h0000_0000);
        rd_chk("output families sdh", sgip_pkg::master_config_6_off, 32'h0000_0000);
        rd_chk("irq config reset", sgip_pkg::irq_pin_config_off, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
